// ### rtl/pfd_defs.svh
// Register offsets, field positions, reset values and counts of the PWM fault and enable control block.
`ifndef PFD_DEFS_SVH
`define PFD_DEFS_SVH

`define PFD_ADDR_W          4
`define PFD_DATA_W          8

`define PFD_OFS_CTRL        4'h0
`define PFD_OFS_FCTRL       4'h1
`define PFD_OFS_FSTAT       4'h2
`define PFD_OFS_FACK        4'h3
`define PFD_OFS_MAPX        4'h4
`define PFD_OFS_MAPY        4'h5
`define PFD_OFS_INDIVIDUAL_PIN_CONTROL      4'h6
`define PFD_OFS_RELOAD      4'h7
`define PFD_OFS_MODH        4'h8
`define PFD_OFS_MODL        4'h9

`define PFD_CTRL_ENABLE     0
`define PFD_CTRL_LOADOK     1
`define PFD_CTRL_PRSC_LO    2
`define PFD_CTRL_PRSC_HI    3
`define PFD_CTRL_RLDIE      4
`define PFD_CTRL_BANK_X_SOFT_DISABLE       5
`define PFD_CTRL_BANK_Y_SOFT_DISABLE       6
`define PFD_INDIVIDUAL_PIN_CONTROL_PINCTL   7
`define PFD_RELOAD_FLAG     0

`define PFD_MAP_RST         6'h3f
`define PFD_PRSC_RST        2'h0
`define PFD_NUM_FAULTS      4
`define PFD_NUM_OUTS        6
`define PFD_MOD_W           12

`endif

// ### rtl/pfd_pkg.sv
// Types shared by the PWM fault and enable control block.
package pfd_pkg;
  typedef logic [5:0]  pfd_outs_t;
  typedef logic [3:0]  pfd_faults_t;
  typedef logic [1:0]  pfd_prsc_t;
  typedef logic [11:0] pfd_mod_t;
  typedef logic [7:0]  pfd_byte_t;
  typedef logic [3:0]  pfd_addr_t;
endpackage

// ### rtl/pfd_fault_filter.sv
// Digital filter for one fault input: level and rising-event outputs.
`timescale 1ns/10ps
`default_nettype none

module pfd_fault_filter (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic faultIn,
  output logic      filtLevel,
  output logic      filtRise
);

  logic [2:0] smp_ff;
  logic       lvl_ff;
  logic       setNow;

  ////////////////////////////////////////////////////////////////////////////
  // Oldest sample low, then two consecutive high samples, makes a fault.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      smp_ff <= 3'h0;
    end else begin
      smp_ff <= {smp_ff[1:0], faultIn};
    end
  end

  assign setNow = !lvl_ff && !smp_ff[2] && smp_ff[1] && smp_ff[0];

  // One low sample ends the filtered level.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lvl_ff <= 1'b0;
    end else if (setNow) begin
      lvl_ff <= 1'b1;
    end else if (lvl_ff && !smp_ff[0]) begin
      lvl_ff <= 1'b0;
    end
  end

  assign filtLevel = lvl_ff;
  assign filtRise  = setNow;

endmodule // pfd_fault_filter

`default_nettype wire

// ### rtl/pfd_fault_ctrl.sv
// PWM fault protection, software disable, disable mapping and module enable control.
`timescale 1ns/10ps
`default_nettype none
`include "pfd_defs.svh"

module pfd_fault_ctrl (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire pfd_pkg::pfd_addr_t regAddr,
  input  wire pfd_pkg::pfd_byte_t regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output pfd_pkg::pfd_byte_t     regRdata,
  input  wire pfd_pkg::pfd_faults_t faultIn,
  input  wire pfd_pkg::pfd_outs_t genOut,
  input  wire logic              cycleStart,
  output pfd_pkg::pfd_outs_t     manual_output_register,
  output pfd_pkg::pfd_outs_t     pwmOe,
  output pfd_pkg::pfd_faults_t   faultIrq,
  output logic                   reloadIrq,
  output logic                   reloadStrobe,
  output logic                   counterRun,
  output pfd_pkg::pfd_mod_t      activeModulus,
  output pfd_pkg::pfd_prsc_t     activePrescaler
);
  import pfd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Mask of outputs disabled by one bank.
  function automatic pfd_outs_t bank_mask(input logic bankOn, input pfd_outs_t map);
    bank_mask = bankOn ? map : 6'h00;
  endfunction
  // Write strobe for one register offset.
  function automatic logic wr_hit(input logic wr, input pfd_addr_t addr, input pfd_addr_t ofs);
    wr_hit = wr && (addr == ofs);
  endfunction
  // Collect the even bits of a byte.
  function automatic pfd_faults_t even_bits(input pfd_byte_t b);
    even_bits = {b[6], b[4], b[2], b[0]};
  endfunction
  // Collect the odd bits of a byte.
  function automatic pfd_faults_t odd_bits(input pfd_byte_t b);
    odd_bits = {b[7], b[5], b[3], b[1]};
  endfunction
  // Interleave two four-bit sets, odd set in the odd positions.
  function automatic pfd_byte_t weave(input pfd_faults_t odd, input pfd_faults_t even);
    weave = {odd[3], even[3], odd[2], even[2], odd[1], even[1], odd[0], even[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic        enable_ff;
  logic        loadOk_ff;
  pfd_prsc_t   prscBuf_ff;
  logic        reloadIe_ff;
  logic [1:0]  softDisBit_ff;
  pfd_faults_t faultIe_ff;
  pfd_faults_t faultMode_ff;
  pfd_faults_t faultFlag_ff;
  pfd_faults_t faultLatch_ff;
  pfd_faults_t faultDis_ff;
  logic [1:0]  softDis_ff;
  pfd_outs_t   mapX_ff;
  pfd_outs_t   mapY_ff;
  logic        mapXDone_ff;
  logic        mapYDone_ff;
  pfd_outs_t   manualOut_ff;
  logic        pinCtl_ff;
  logic        reloadFlag_ff;
  pfd_mod_t    modBuf_ff;
  pfd_mod_t    modAct_ff;
  pfd_prsc_t   prscAct_ff;
  logic        oeHold_ff;
  pfd_outs_t   manual_output_register_ff;
  pfd_outs_t   pwmOe_ff;
  pfd_byte_t   rdata_ff;
  pfd_faults_t filtLevel;
  pfd_faults_t filtRise;
  pfd_faults_t ackHit;
  pfd_faults_t clearOk;
  logic        enableRise;
  logic        reloadNow;
  logic        clearPoint;
  logic        bankX;
  logic        bankY;
  pfd_outs_t   disMask;
  pfd_outs_t   nxt_drive;
  pfd_byte_t   nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < `PFD_NUM_FAULTS; i++) begin : gFilt
    pfd_fault_filter uFilt (
      .mclk      (mclk),
      .rstn      (rstn),
      .faultIn   (faultIn[i]),
      .filtLevel (filtLevel[i]),
      .filtRise  (filtRise[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  assign enableRise = wr_hit(regWr, regAddr, `PFD_OFS_CTRL) && regWdata[`PFD_CTRL_ENABLE] && !enable_ff;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enable_ff     <= 1'b0;
      prscBuf_ff    <= `PFD_PRSC_RST;
      reloadIe_ff   <= 1'b0;
      softDisBit_ff <= 2'h0;
    end else if (wr_hit(regWr, regAddr, `PFD_OFS_CTRL)) begin
      enable_ff     <= regWdata[`PFD_CTRL_ENABLE];
      prscBuf_ff    <= regWdata[`PFD_CTRL_PRSC_HI:`PFD_CTRL_PRSC_LO];
      reloadIe_ff   <= regWdata[`PFD_CTRL_RLDIE];
      softDisBit_ff <= {regWdata[`PFD_CTRL_BANK_Y_SOFT_DISABLE], regWdata[`PFD_CTRL_BANK_X_SOFT_DISABLE]};
    end
  end

  // Load okay is consumed by the reload that uses it.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      loadOk_ff <= 1'b0;
    end else if (wr_hit(regWr, regAddr, `PFD_OFS_CTRL) && regWdata[`PFD_CTRL_LOADOK]) begin
      loadOk_ff <= 1'b1;
    end else if (reloadNow) begin
      loadOk_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reloadNow = enableRise || (enable_ff && cycleStart);

  // The period holds no reset so a stale value survives; zero is illegal.
  always_ff @(posedge mclk) begin
    if (wr_hit(regWr, regAddr, `PFD_OFS_MODH)) begin
      modBuf_ff[11:8] <= regWdata[3:0];
    end
    if (wr_hit(regWr, regAddr, `PFD_OFS_MODL)) begin
      modBuf_ff[7:0] <= regWdata;
    end
    if (reloadNow && loadOk_ff) begin
      modAct_ff <= modBuf_ff;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prscAct_ff <= `PFD_PRSC_RST;
    end else if (reloadNow && loadOk_ff) begin
      prscAct_ff <= prscBuf_ff;
    end
  end

  // Disabling leaves the flag alone; a reload set beside a clear wins.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reloadFlag_ff <= 1'b0;
    end else if (reloadNow) begin
      reloadFlag_ff <= 1'b1;
    end else if (wr_hit(regWr, regAddr, `PFD_OFS_RELOAD) && regWdata[`PFD_RELOAD_FLAG]) begin
      reloadFlag_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ackHit = wr_hit(regWr, regAddr, `PFD_OFS_FACK) ? even_bits(regWdata) : 4'h0;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultIe_ff   <= 4'h0;
      faultMode_ff <= 4'h0;
    end else if (wr_hit(regWr, regAddr, `PFD_OFS_FCTRL)) begin
      faultIe_ff   <= even_bits(regWdata);
      faultMode_ff <= odd_bits(regWdata);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultFlag_ff <= 4'h0;
    end else begin
      faultFlag_ff <= filtRise | (faultFlag_ff & ~ackHit);
    end
  end

  // A vector fetch has no port here, so it cannot disturb any of this state.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultLatch_ff <= 4'h0;
    end else begin
      faultLatch_ff <= faultIe_ff & ((filtRise & faultIe_ff) | (faultLatch_ff & ~ackHit));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // With pin control there are no PWM cycles, so every clock is a clear point.
  assign clearPoint = pinCtl_ff || cycleStart;

  always_comb begin
    for (int i = 0; i < `PFD_NUM_FAULTS; i++) begin
      if (faultMode_ff[i]) begin
        clearOk[i] = !filtLevel[i];
      end else if (i == 0 || i == 2) begin
        clearOk[i] = !faultFlag_ff[i];
      end else begin
        clearOk[i] = !faultFlag_ff[i] && !filtLevel[i];
      end
    end
  end

  // Faults keep working whatever the module enable says.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultDis_ff <= 4'h0;
    end else begin
      for (int i = 0; i < `PFD_NUM_FAULTS; i++) begin
        if (filtRise[i]) begin
          faultDis_ff[i] <= 1'b1;
        end else if (clearPoint && clearOk[i]) begin
          faultDis_ff[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      softDis_ff <= 2'h0;
    end else begin
      softDis_ff <= softDisBit_ff | (softDis_ff & ~{2{clearPoint}});
    end
  end

  // The rising event disables at once, before the latch has even been set.
  assign bankX   = filtRise[0] | filtRise[1] | faultDis_ff[0] | faultDis_ff[1] | softDisBit_ff[0] | softDis_ff[0];
  assign bankY   = filtRise[2] | filtRise[3] | faultDis_ff[2] | faultDis_ff[3] | softDisBit_ff[1] | softDis_ff[1];
  assign disMask = bank_mask(bankX, mapX_ff) | bank_mask(bankY, mapY_ff);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mapX_ff     <= `PFD_MAP_RST;
      mapXDone_ff <= 1'b0;
    end else if (wr_hit(regWr, regAddr, `PFD_OFS_MAPX) && !mapXDone_ff) begin
      mapX_ff     <= regWdata[5:0];
      mapXDone_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mapY_ff     <= `PFD_MAP_RST;
      mapYDone_ff <= 1'b0;
    end else if (wr_hit(regWr, regAddr, `PFD_OFS_MAPY) && !mapYDone_ff) begin
      mapY_ff     <= regWdata[5:0];
      mapYDone_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      manualOut_ff <= 6'h00;
      pinCtl_ff    <= 1'b0;
    end else if (wr_hit(regWr, regAddr, `PFD_OFS_INDIVIDUAL_PIN_CONTROL)) begin
      manualOut_ff <= regWdata[5:0];
      pinCtl_ff    <= regWdata[`PFD_INDIVIDUAL_PIN_CONTROL_PINCTL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow prescalers keep the pins floating until the first cycle has run.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oeHold_ff <= 1'b0;
    end else if (enableRise) begin
      oeHold_ff <= (prscBuf_ff != 2'h0);
    end else if (cycleStart || !enable_ff) begin
      oeHold_ff <= 1'b0;
    end
  end

  always_comb begin
    if (pinCtl_ff) begin
      nxt_drive = manualOut_ff;
    end else if (enable_ff) begin
      nxt_drive = genOut;
    end else begin
      nxt_drive = 6'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      manual_output_register_ff <= 6'h00;
      pwmOe_ff  <= 6'h00;
    end else begin
      manual_output_register_ff <= nxt_drive & ~disMask;
      pwmOe_ff  <= {6{pinCtl_ff || (enable_ff && !oeHold_ff && !enableRise)}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        `PFD_OFS_CTRL:   nxt_rdata = {1'b0, softDisBit_ff, reloadIe_ff, prscBuf_ff, loadOk_ff, enable_ff};
        `PFD_OFS_FCTRL:  nxt_rdata = weave(faultMode_ff, faultIe_ff);
        `PFD_OFS_FSTAT:  nxt_rdata = weave(filtLevel, faultFlag_ff);
        `PFD_OFS_MAPX:   nxt_rdata = {2'h0, mapX_ff};
        `PFD_OFS_MAPY:   nxt_rdata = {2'h0, mapY_ff};
        `PFD_OFS_INDIVIDUAL_PIN_CONTROL: nxt_rdata = {pinCtl_ff, 1'b0, manualOut_ff};
        `PFD_OFS_RELOAD: nxt_rdata = {7'h00, reloadFlag_ff};
        `PFD_OFS_MODH:   nxt_rdata = {4'h0, modBuf_ff[11:8]};
        `PFD_OFS_MODL:   nxt_rdata = modBuf_ff[7:0];
        default:         nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign regRdata        = rdata_ff;
  assign manual_output_register          = manual_output_register_ff;
  assign pwmOe           = pwmOe_ff;
  assign faultIrq        = faultLatch_ff;
  assign reloadIrq       = reloadFlag_ff && reloadIe_ff;
  assign reloadStrobe    = reloadNow;
  assign counterRun      = enable_ff;
  assign activeModulus   = modAct_ff;
  assign activePrescaler = prscAct_ff;

endmodule // pfd_fault_ctrl

`default_nettype wire

// ### tb/pfd_fault_ctrl_properties.sv
// Concurrent checks on the ports of the PWM fault and enable control block.
`timescale 1ns/10ps
`default_nettype none

module pfd_fault_ctrl_chk (
  input wire logic                 mclk,
  input wire logic                 rstn,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire pfd_pkg::pfd_byte_t   regRdata,
  input wire pfd_pkg::pfd_faults_t faultIn,
  input wire pfd_pkg::pfd_outs_t   manual_output_register,
  input wire pfd_pkg::pfd_outs_t   pwmOe,
  input wire pfd_pkg::pfd_faults_t faultIrq,
  input wire logic                 reloadStrobe,
  input wire logic                 counterRun,
  input wire pfd_pkg::pfd_prsc_t   activePrescaler
);
  import pfd_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_fast_start;
    $rose(counterRun) && activePrescaler == 2'h0;
  endsequence

  a_oe_uniform: assert property (pwmOe == 6'h00 || pwmOe == 6'h3f)
    else $error("pin enables differ");
  a_fast_drive: assert property (s_fast_start |-> ##[0:2] (pwmOe == 6'h3f))
    else $error("pins not driven soon after enable");
  a_enable_reloads: assert property ($rose(counterRun) |-> $past(reloadStrobe))
    else $error("enable without reload");
  a_off_pins_low: assert property (!counterRun && !pwmOe[0] |-> manual_output_register == 6'h00)
    else $error("pin data while disabled");
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside read slot");
  a_reset_clears: assert property (disable iff (1'b0) !rstn |-> faultIrq == 4'h0 && pwmOe == 6'h00)
    else $error("reset did not clear state");

  for (genvar k = 0; k < 4; k++) begin : g_flt
    a_filter_two_high: assert property ($rose(faultIrq[k]) |->
      $past(faultIn[k], 2) && $past(faultIn[k], 3) && !$past(faultIn[k], 4))
      else $error("latch set without filtered rise");
    a_irq_write_clears: assert property ($fell(faultIrq[k]) |-> $past(regWr))
      else $error("latch cleared without write");
  end
endmodule // pfd_fault_ctrl_chk

bind pfd_fault_ctrl pfd_fault_ctrl_chk u_chk (
  .mclk(mclk),
  .rstn(rstn),
  .regWr(regWr),
  .regRd(regRd),
  .regRdata(regRdata),
  .faultIn(faultIn),
  .manual_output_register(manual_output_register),
  .pwmOe(pwmOe),
  .faultIrq(faultIrq),
  .reloadStrobe(reloadStrobe),
  .counterRun(counterRun),
  .activePrescaler(activePrescaler)
);

`default_nettype wire

// ### tb/pfd_drive_model.sv
// Fault source model standing for the external power drive circuitry.
`timescale 1ns/10ps
`default_nettype none

module pfd_drive_model (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire pfd_pkg::pfd_faults_t tripReq,
  input  wire pfd_pkg::pfd_faults_t glitchReq,
  output pfd_pkg::pfd_faults_t      faultIn
);
  import pfd_pkg::*;

  // A glitch lasts one clock, so the filter sees a single high sample only.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultIn <= 4'h0;
    end else begin
      faultIn <= tripReq | glitchReq;
    end
  end
endmodule // pfd_drive_model

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the PWM fault and enable control block.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); fail_count++; end end

module tb;
  import pfd_pkg::*;

  logic        mclk;
  logic        rstn;
  pfd_addr_t   regAddr;
  pfd_byte_t   regWdata;
  pfd_byte_t   regRdata;
  logic        regWr;
  logic        regRd;
  pfd_faults_t faultIn;
  pfd_faults_t faultIrq;
  pfd_faults_t tripReq;
  pfd_faults_t glitchReq;
  pfd_outs_t   genOut;
  pfd_outs_t   manual_output_register;
  pfd_outs_t   pwmOe;
  logic        cycleStart;
  logic        reloadIrq;
  logic        reloadStrobe;
  logic        counterRun;
  logic        csOn;
  logic [2:0]  csCnt;
  logic [5:0]  man;
  pfd_mod_t    activeModulus;
  pfd_mod_t    modVal;
  pfd_prsc_t   activePrescaler;
  int          seed = 28;
  int          fail_count = 0;
  int          checked = 0;

  pfd_fault_ctrl u_dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .faultIn(faultIn), .genOut(genOut), .cycleStart(cycleStart),
    .manual_output_register(manual_output_register), .pwmOe(pwmOe), .faultIrq(faultIrq), .reloadIrq(reloadIrq), .reloadStrobe(reloadStrobe),
    .counterRun(counterRun), .activeModulus(activeModulus), .activePrescaler(activePrescaler));

  pfd_drive_model u_drv (.mclk(mclk), .rstn(rstn), .tripReq(tripReq), .glitchReq(glitchReq), .faultIn(faultIn));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Period of eight clocks stands in for the PWM counter wrap.
  always @(posedge mclk) begin
    csCnt <= csCnt + 3'h1;
    cycleStart <= csOn && csCnt == 3'h7;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    print_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic bit reen(input int m, input int i);
    return m == 0 && i % 2 == 0;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input pfd_addr_t a, input pfd_byte_t d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input pfd_addr_t a, input pfd_byte_t e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask

  task automatic sync;
    int n;
    n = 0;
    while (cycleStart !== 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    if (n == 50) begin
      fail_count++;
      print_verdict;
    end
  endtask

  task automatic print_verdict;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    tripReq = 4'h0;
    glitchReq = 4'h0;
    genOut = 6'h00;
    cycleStart = 1'b0;
    csCnt = 3'h0;
    csOn = 1'b0;
    cyc(3);
    rstn = 1'b1;
    `CHK("pwmOe", 6'h00, pwmOe)
    `CHK("activePrescaler", 2'h0, activePrescaler)
    rd(4'hf, 8'h00);
    wr(4'h1, 8'h55);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      glitchReq <= 4'h1 << i;
      genOut <= 6'($random(seed));
      @(posedge mclk);
      glitchReq <= 4'h0;
      cyc(4);
      `CHK("faultIrq", 4'h0, faultIrq)
    end
    rd(4'h2, 8'h00);
    modVal = 12'($random(seed)) | 12'h001;
    genOut <= 6'h3f;
    wr(4'h8, {4'h0, modVal[11:8]});
    wr(4'h9, modVal[7:0]);
    wr(4'h0, 8'h02);
    wr(4'h0, 8'h01);
    csOn <= 1'b1;
    cyc(3);
    `CHK("counterRun", 1'b1, counterRun)
    `CHK("pwmOe", 6'h3f, pwmOe)
    `CHK("activeModulus", modVal, activeModulus)
    rd(4'h7, 8'h01);
    for (int m = 0; m < 2; m++) begin
      wr(4'h1, m ? 8'haa : 8'h55);
      for (int i = 0; i < 4; i++) begin
        tripReq[i] <= 1'b1;
        cyc(6);
        `CHK("manual_output_register", 6'h00, manual_output_register)
        `CHK("faultIrq", m ? 4'h0 : 4'(1 << i), faultIrq)
        rd(4'h2, 8'(3 << (2 * i)));
        wr(4'h3, 8'(1 << (2 * i)));
        cyc(12);
        `CHK("manual_output_register", reen(m, i) ? 6'h3f : 6'h00, manual_output_register)
        `CHK("faultIrq", 4'h0, faultIrq)
        tripReq[i] <= 1'b0;
        cyc(12);
        `CHK("manual_output_register", 6'h3f, manual_output_register)
      end
    end
    wr(4'h4, 8'h0f);
    wr(4'h4, 8'h3f);
    wr(4'h0, 8'h21);
    cyc(2);
    `CHK("manual_output_register", 6'h30, manual_output_register)
    rd(4'h2, 8'h00);
    sync;
    wr(4'h0, 8'h01);
    cyc(1);
    `CHK("manual_output_register", 6'h30, manual_output_register)
    cyc(10);
    `CHK("manual_output_register", 6'h3f, manual_output_register)
    wr(4'h0, 8'h41);
    cyc(2);
    `CHK("manual_output_register", 6'h00, manual_output_register)
    wr(4'h0, 8'h00);
    csOn <= 1'b0;
    cyc(2);
    `CHK("pwmOe", 6'h00, pwmOe)
    rd(4'h7, 8'h01);
    wr(4'h7, 8'h01);
    rd(4'h7, 8'h00);
    man = 6'($random(seed));
    wr(4'h6, {2'b10, man});
    cyc(2);
    `CHK("pwmOe", 6'h3f, pwmOe)
    `CHK("manual_output_register", man, manual_output_register)
    wr(4'h1, 8'h55);
    tripReq[0] <= 1'b1;
    cyc(6);
    `CHK("manual_output_register", man & 6'h30, manual_output_register)
    wr(4'h3, 8'h01);
    cyc(2);
    `CHK("manual_output_register", man, manual_output_register)
    tripReq[0] <= 1'b0;
    wr(4'h6, 8'h00);
    csOn <= 1'b1;
    wr(4'h0, 8'h16);
    sync;
    wr(4'h0, 8'h15);
    cyc(1);
    `CHK("pwmOe", 6'h00, pwmOe)
    `CHK("activePrescaler", 2'h1, activePrescaler)
    `CHK("reloadIrq", 1'b1, reloadIrq)
    cyc(10);
    `CHK("pwmOe", 6'h3f, pwmOe)
    `CHK("activeModulus", modVal, activeModulus)
    print_verdict;
  end
endmodule // tb

`default_nettype wire
